// file: hdl/es_pkg.sv
/*
  Shared constants for the energy-sum pulse-rate scaler: register map, event
  bits, rate and multiplier tables, transfer-function scaling and pulse times.
  Assumes a 32-bit AXI4-Lite register bus and signed per-phase power words.
*/
package es_pkg;

  localparam int ES_CLK_HZ     = 50_000_000;
  localparam int ES_MS_PER_S   = 1000;
  localparam int ES_CHZ_PER_HZ = 100;
  localparam int ES_NSEL       = 8;

  // Indexed by {cal_scale_select, rate_select_hi, rate_select_lo}
  localparam int ES_BASE_CHZ [ES_NSEL] = '{127, 509, 1907, 7629, 119, 477, 1907, 60};
  localparam int ES_CF_MULT  [ES_NSEL] = '{160, 160, 16, 8, 8, 16, 8, 16};
  localparam logic [2:0] ES_SEL_DUTY = 3'h1;
  localparam int ES_CF_DUTY_PCT      = 66;
  localparam int ES_PCT_FULL         = 100;

  // Phase power word: a dc product of 0.5 V by 0.5 V reads as ES_PHASE_FS
  localparam int ES_PW         = 24;
  localparam int ES_SW         = ES_PW + 2;
  localparam int ES_PHASE_FS   = 4194304;
  localparam int ES_GAIN_X1000 = 5922;
  localparam int ES_FS_MV      = 500;
  localparam int ES_VREF_MV    = 2400;
  localparam int ES_ACC_MULT   = 256;
  localparam int ES_ACC_W      = 40;
  localparam longint ES_THRESH =
    (longint'(ES_ACC_MULT) * ES_PHASE_FS * ES_VREF_MV * ES_VREF_MV * ES_MS_PER_S) /
    (longint'(ES_GAIN_X1000) * ES_FS_MV * ES_FS_MV);
  localparam logic [ES_ACC_W-1:0] ES_STEP_AB = ES_ACC_W'(ES_THRESH / 2);

  localparam int ES_NOLOAD_PPM   = 50;
  localparam int ES_PPM_FULL     = 1_000_000;
  // Multiply before dividing so the creep level does not truncate to zero
  localparam int ES_NOLOAD_LEVEL = 3 * ES_PHASE_FS * ES_NOLOAD_PPM / ES_PPM_FULL;
  localparam int ES_NOLOAD_PHASE = ES_NOLOAD_LEVEL / 3;

  localparam int ES_AB_WIDTH_MS = 275;
  localparam int ES_CF_WIDTH_MS = 76;
  localparam int ES_CF_SHORT_MS = 192;
  localparam int ES_CW          = 28;

  localparam int         ES_ADDR_W     = 8;
  localparam logic [7:0] ES_REG_CTRL   = 8'h00;
  localparam logic [7:0] ES_REG_STATUS = 8'h04;
  localparam logic [7:0] ES_REG_MASK   = 8'h08;
  localparam logic [7:0] ES_REG_STATE  = 8'h0c;

  localparam int ES_CTRL_EN     = 0;
  localparam logic ES_CTRL_EN_RST = 1'b1;
  localparam int ES_EV_A        = 0;
  localparam int ES_EV_B        = 1;
  localparam int ES_EV_CF       = 2;
  localparam int ES_EV_REV      = 3;
  localparam int ES_NEV         = 4;
  localparam int ES_ST_REV      = 0;
  localparam int ES_ST_NOLOAD   = 1;
  localparam int ES_ST_SEL_LSB  = 2;
  localparam int ES_ST_ARITH    = 5;

  localparam logic [1:0] ES_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ES_RESP_SLVERR = 2'h2;

  typedef enum logic {
    ES_TURN_A = 1'b0,
    ES_TURN_B = 1'b1
  } es_turn_t;

endpackage

// file: hdl/es_shaper_if.sv
/*
  Carrier between the scaler core and one pulse shaper: trigger, width
  settings and the shaped pulse. Assumes both ends share aclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface es_shaper_if #(parameter int CW = 28);
  logic          trig;
  logic [CW-1:0] width;
  logic [CW-1:0] short_lim;
  logic          duty_mode;
  logic          pulse;
  modport src (output trig, output width, output short_lim, output duty_mode, input pulse);
  modport shp (input trig, input width, input short_lim, input duty_mode, output pulse);
endinterface
`default_nettype wire

// file: hdl/es_pulse_shaper.sv
/*
  One output pulse shaper: stretches a one-cycle trigger to the nominal width,
  or to a fraction of the measured period when triggers come quickly or duty_mode is set.
  Assumes triggers are one-cycle pulses synchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module es_pulse_shaper
  import es_pkg::*;
#(
  parameter int CW = ES_CW
) (
  input wire logic aclk,
  input wire logic aresetn,
  es_shaper_if.shp s
);

  if (CW < 2 || CW > 32) begin : g_bad_cw
    $error("CW outside the range the shaper can serve");
  end

  localparam logic [6:0] DUTY_PCT = 7'(ES_CF_DUTY_PCT);
  localparam logic [6:0] PCT_FULL = 7'(ES_PCT_FULL);

  logic [CW-1:0]   since_q;
  logic [CW-1:0]   hold_q;
  logic            seen_q;
  logic            out_q;
  logic [CW-1:0]   width_d;
  logic [CW+6:0]   duty_prod;

  // Period counter saturates so an idle output never wraps into a short period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_q <= '0;
      seen_q  <= 1'b0;
    end else if (s.trig) begin
      since_q <= '0;
      seen_q  <= 1'b1;
    end else if (since_q != '1) begin
      since_q <= since_q + 1'b1;
    end
  end

  always_comb begin
    duty_prod = ({7'h00, since_q} * DUTY_PCT) / PCT_FULL;
    if (!seen_q) begin
      width_d = s.width;
    end else if (s.duty_mode) begin
      width_d = duty_prod[CW-1:0];
    end else if (since_q < s.short_lim) begin
      width_d = since_q >> 1;
    end else begin
      width_d = s.width;
    end
    if (width_d == '0) begin
      width_d = CW'(1);
    end
  end

  // A trigger during a pulse restarts it, so the two pulses merge into one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= '0;
      out_q  <= 1'b0;
    end else if (s.trig) begin
      hold_q <= width_d - 1'b1;
      out_q  <= 1'b1;
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 1'b1;
    end else begin
      out_q  <= 1'b0;
    end
  end

  assign s.pulse = out_q;

endmodule
`default_nettype wire

// file: hdl/es_pulse_rate_scaler.sv
/*
  Energy-sum pulse-rate scaler: sums three phase powers, converts the sum to
  two alternating low-rate pulse outputs and a calibration pulse output, keeps
  a reverse-power flag, and offers control, status and interrupt registers on
  AXI4-Lite. Assumes phase power words are low-pass-filtered real power,
  synchronous to aclk, and that mode pins are synchronous to aclk.
*/
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module es_pulse_rate_scaler
  import es_pkg::*;
#(
  parameter int CLK_HZ = ES_CLK_HZ
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic signed [ES_PW-1:0] phase_power_a,
  input  wire logic signed [ES_PW-1:0] phase_power_b,
  input  wire logic signed [ES_PW-1:0] phase_power_c,
  input  wire logic                    magnitude_sum_select_n,
  input  wire logic                    cal_scale_select,
  input  wire logic                    rate_select_hi,
  input  wire logic                    rate_select_lo,
  output logic                         pulse_out_a,
  output logic                         pulse_out_b,
  output logic                         calibration_pulse_out,
  output logic                         reverse_power_flag,
  output logic                         irq,
  input  wire logic [ES_ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ES_ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);

  localparam int CYC_PER_MS  = CLK_HZ / ES_MS_PER_S;
  localparam int AB_WIDTH_CY = ES_AB_WIDTH_MS * CYC_PER_MS;
  localparam int CF_WIDTH_CY = ES_CF_WIDTH_MS * CYC_PER_MS;
  localparam int CF_SHORT_CY = ES_CF_SHORT_MS * CYC_PER_MS;
  localparam int MIN_CLK_HZ  = 2 * ES_MS_PER_S * ES_ACC_MULT;

  if (CLK_HZ < MIN_CLK_HZ || 2 * AB_WIDTH_CY >= (1 << (ES_CW - 1))) begin : g_bad_clk
    $error("CLK_HZ outside the range the dividers and shapers can serve");
  end

  function automatic logic [31:0] es_div(input logic [2:0] s);
    es_div = 32'(longint'(CLK_HZ) * ES_CHZ_PER_HZ /
                 (longint'(ES_BASE_CHZ[s]) * ES_ACC_MULT));
  endfunction

  function automatic logic [ES_SW-1:0] es_abs(input logic signed [ES_SW-1:0] v);
    es_abs = v[ES_SW-1] ? ES_SW'(-v) : ES_SW'(v);
  endfunction

  // Pin sampling
  logic [2:0] sel_q;
  logic       arith_q;
  logic       sel_chg;

  assign sel_chg = {cal_scale_select, rate_select_hi, rate_select_lo} != sel_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q   <= 3'h0;
      arith_q <= 1'b1;
    end else begin
      sel_q   <= {cal_scale_select, rate_select_hi, rate_select_lo};
      arith_q <= magnitude_sum_select_n;
    end
  end

  // Accumulation tick at ES_ACC_MULT times the base rate
  logic [31:0] div_cnt_q;
  logic        acc_tick;

  assign acc_tick = (div_cnt_q == es_div(sel_q) - 32'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn || sel_chg) begin
      div_cnt_q <= 32'h0;
    end else if (acc_tick) begin
      div_cnt_q <= 32'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 32'h1;
    end
  end

  // Summation
  logic signed [ES_SW-1:0] ext_a;
  logic signed [ES_SW-1:0] ext_b;
  logic signed [ES_SW-1:0] ext_c;
  logic signed [ES_SW-1:0] sum_arith;
  logic        [ES_SW-1:0] sum_mag;
  logic        [ES_SW-1:0] total_mag;
  logic                    noload;
  logic                    neg_now;

  always_comb begin
    ext_a     = ES_SW'(phase_power_a);
    ext_b     = ES_SW'(phase_power_b);
    ext_c     = ES_SW'(phase_power_c);
    sum_arith = ext_a + ext_b + ext_c;
    sum_mag   = es_abs(ext_a) + es_abs(ext_b) + es_abs(ext_c);
    total_mag = arith_q ? es_abs(sum_arith) : sum_mag;
    noload    = total_mag < ES_SW'(ES_NOLOAD_LEVEL);
    // Phases resting under a third of the creep level are kept out of the reverse test
    neg_now   = (ext_a < -ES_SW'(ES_NOLOAD_PHASE)) ||
                (ext_b < -ES_SW'(ES_NOLOAD_PHASE)) ||
                (ext_c < -ES_SW'(ES_NOLOAD_PHASE));
  end

  // Digital-to-frequency conversion
  logic [ES_ACC_W-1:0] acc_ab_q;
  logic [ES_ACC_W-1:0] acc_cf_q;
  logic [ES_ACC_W-1:0] acc_ab_sum;
  logic [ES_ACC_W-1:0] acc_cf_sum;
  logic [ES_ACC_W-1:0] cf_step;
  logic                run;
  logic                ctrl_en_q;
  es_turn_t            turn_q;
  logic                trig_a_q;
  logic                trig_b_q;
  logic                trig_cf_q;
  logic                noload_q;

  assign run        = acc_tick && ctrl_en_q && !noload;
  assign acc_ab_sum = acc_ab_q + ES_ACC_W'(total_mag);
  assign acc_cf_sum = acc_cf_q + ES_ACC_W'(total_mag);
  assign cf_step    = ES_ACC_W'(ES_THRESH / longint'(ES_CF_MULT[sel_q]));

  // The filtered mean is what accumulates, so an ac full scale lands at half the dc rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ab_q <= '0;
      turn_q   <= ES_TURN_A;
      trig_a_q <= 1'b0;
      trig_b_q <= 1'b0;
    end else begin
      trig_a_q <= 1'b0;
      trig_b_q <= 1'b0;
      if (run) begin
        if (acc_ab_sum >= ES_STEP_AB) begin
          acc_ab_q <= acc_ab_sum - ES_STEP_AB;
          trig_a_q <= (turn_q == ES_TURN_A);
          trig_b_q <= (turn_q == ES_TURN_B);
          turn_q   <= (turn_q == ES_TURN_A) ? ES_TURN_B : ES_TURN_A;
        end else begin
          acc_ab_q <= acc_ab_sum;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_cf_q  <= '0;
      trig_cf_q <= 1'b0;
    end else begin
      trig_cf_q <= 1'b0;
      if (run) begin
        if (acc_cf_sum >= cf_step) begin
          acc_cf_q  <= acc_cf_sum - cf_step;
          trig_cf_q <= 1'b1;
        end else begin
          acc_cf_q  <= acc_cf_sum;
        end
      end
    end
  end

  // Reverse flag moves only with a calibration pulse, like the pulse outputs
  logic rev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rev_q    <= 1'b0;
      noload_q <= 1'b1;
    end else begin
      if (trig_cf_q) begin
        rev_q <= neg_now;
      end
      if (acc_tick) begin
        noload_q <= noload;
      end
    end
  end

  // Pulse shapers: 0 and 1 are the low-rate pair, 2 the calibration output
  localparam int NCH = 3;
  es_shaper_if #(.CW(ES_CW)) shp_if [NCH] ();
  logic [NCH-1:0] ch_trig;
  logic [NCH-1:0] ch_pulse;

  assign ch_trig = {trig_cf_q, trig_b_q, trig_a_q};

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    localparam bit IS_CF = (g == NCH - 1);
    assign shp_if[g].trig      = ch_trig[g];
    assign shp_if[g].width     = ES_CW'(IS_CF ? CF_WIDTH_CY : AB_WIDTH_CY);
    assign shp_if[g].short_lim = ES_CW'(IS_CF ? CF_SHORT_CY : 2 * AB_WIDTH_CY);
    assign shp_if[g].duty_mode = IS_CF && (sel_q == ES_SEL_DUTY);
    assign ch_pulse[g]         = shp_if[g].pulse;
    es_pulse_shaper #(.CW(ES_CW)) u_shaper (
      .aclk    (aclk),
      .aresetn (aresetn),
      .s       (shp_if[g])
    );
  end

  assign pulse_out_a           = ch_pulse[0];
  assign pulse_out_b           = ch_pulse[1];
  assign calibration_pulse_out = ch_pulse[2];
  assign reverse_power_flag    = rev_q;

  // AXI4-Lite slave
  logic                 aw_full_q;
  logic                 w_full_q;
  logic [ES_ADDR_W-1:0] awaddr_q;
  logic [31:0]          wdata_q;
  logic [3:0]           wstrb_q;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 rvalid_q;
  logic [31:0]          rdata_q;
  logic [1:0]           rresp_q;
  logic                 do_wr;
  logic                 hit_ctrl;
  logic                 hit_status;
  logic                 hit_mask;
  logic                 hit_state;

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign do_wr         = aw_full_q && w_full_q && !bvalid_q;
  assign hit_ctrl      = awaddr_q[ES_ADDR_W-1:2] == ES_REG_CTRL[ES_ADDR_W-1:2];
  assign hit_status    = awaddr_q[ES_ADDR_W-1:2] == ES_REG_STATUS[ES_ADDR_W-1:2];
  assign hit_mask      = awaddr_q[ES_ADDR_W-1:2] == ES_REG_MASK[ES_ADDR_W-1:2];
  assign hit_state     = awaddr_q[ES_ADDR_W-1:2] == ES_REG_STATE[ES_ADDR_W-1:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && !aw_full_q) begin
      aw_full_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && !w_full_q) begin
      w_full_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_wr) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= ES_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (hit_ctrl || hit_status || hit_mask || hit_state) ?
                  ES_RESP_OKAY : ES_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Registers, events and interrupt
  logic [ES_NEV-1:0] status_q;
  logic [ES_NEV-1:0] mask_q;
  logic [ES_NEV-1:0] events;
  logic [ES_NEV-1:0] status_clr;
  logic              rev_prev_q;
  logic              irq_q;
  logic              wr_lane0;

  assign wr_lane0   = do_wr && wstrb_q[0];
  assign status_clr = (wr_lane0 && hit_status) ? wdata_q[ES_NEV-1:0] : '0;

  always_comb begin
    events            = '0;
    events[ES_EV_A]   = trig_a_q;
    events[ES_EV_B]   = trig_b_q;
    events[ES_EV_CF]  = trig_cf_q;
    events[ES_EV_REV] = rev_q && !rev_prev_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en_q <= ES_CTRL_EN_RST;
      mask_q    <= '0;
    end else if (wr_lane0) begin
      if (hit_ctrl) begin
        ctrl_en_q <= wdata_q[ES_CTRL_EN];
      end else if (hit_mask) begin
        mask_q <= wdata_q[ES_NEV-1:0];
      end
    end
  end

  // An event landing with its clear stays set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q   <= '0;
      rev_prev_q <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      status_q   <= (status_q & ~status_clr) | events;
      rev_prev_q <= rev_q;
      irq_q      <= |(status_q & mask_q);
    end
  end

  assign irq = irq_q;

  logic [31:0] rd_word;
  logic        rd_ok;

  always_comb begin
    rd_word = 32'h0;
    rd_ok   = 1'b1;
    if (s_axi_araddr[ES_ADDR_W-1:2] == ES_REG_CTRL[ES_ADDR_W-1:2]) begin
      rd_word[ES_CTRL_EN] = ctrl_en_q;
    end else if (s_axi_araddr[ES_ADDR_W-1:2] == ES_REG_STATUS[ES_ADDR_W-1:2]) begin
      rd_word[ES_NEV-1:0] = status_q;
    end else if (s_axi_araddr[ES_ADDR_W-1:2] == ES_REG_MASK[ES_ADDR_W-1:2]) begin
      rd_word[ES_NEV-1:0] = mask_q;
    end else if (s_axi_araddr[ES_ADDR_W-1:2] == ES_REG_STATE[ES_ADDR_W-1:2]) begin
      rd_word[ES_ST_REV]            = rev_q;
      rd_word[ES_ST_NOLOAD]         = noload_q;
      rd_word[ES_ST_SEL_LSB +: 3]   = sel_q;
      rd_word[ES_ST_ARITH]          = arith_q;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= ES_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_ok ? ES_RESP_OKAY : ES_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: verif/es_pulse_counter.sv
/*
  Pulse counter at the far side of the three pulse outputs.
  Assumes pulses are levels synchronous to aclk; counts restart in reset.
*/
`timescale 1ns/1ps
`default_nettype none
module es_pulse_counter (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pulse_out_a,
  input  wire logic pulse_out_b,
  input  wire logic calibration_pulse_out,
  output int        n_a,
  output int        n_b,
  output int        n_cf,
  output int        t_a,
  output int        t_b,
  output int        t_cf
);
  int   cyc;
  logic a_q, b_q, cf_q;
  // Counts over the whole run: a short window could lose a pulse to phase
  always_ff @(posedge aclk) begin
    a_q  <= pulse_out_a;
    b_q  <= pulse_out_b;
    cf_q <= calibration_pulse_out;
    if (!aresetn) begin
      {cyc, n_a, n_b, n_cf} <= '0;
    end else begin
      cyc <= cyc + 1;
      if (pulse_out_a && !a_q && n_a == 0) t_a <= cyc;
      if (pulse_out_a && !a_q) n_a <= n_a + 1;
      if (pulse_out_b && !b_q && n_b == 0) t_b <= cyc;
      if (pulse_out_b && !b_q) n_b <= n_b + 1;
      if (calibration_pulse_out && !cf_q && n_cf == 0) t_cf <= cyc;
      if (calibration_pulse_out && !cf_q) n_cf <= n_cf + 1;
    end
  end
endmodule
`default_nettype wire

// file: verif/es_pulse_rate_scaler_asserts.sv
/*
  Port checker for the pulse-rate scaler.
  Assumes one clock aclk and synchronous active-low aresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module es_pulse_rate_scaler_asserts
  import es_pkg::*;
(
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic signed [ES_PW-1:0] phase_power_a,
  input wire logic signed [ES_PW-1:0] phase_power_b,
  input wire logic signed [ES_PW-1:0] phase_power_c,
  input wire logic                    pulse_out_a,
  input wire logic                    pulse_out_b,
  input wire logic                    calibration_pulse_out,
  input wire logic                    reverse_power_flag,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_rvalid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic load, neg;
  // Any power at all is a necessary cause only, weaker than the creep level
  assign load = |{phase_power_a, phase_power_b, phase_power_c};
  assign neg  = phase_power_a[ES_PW-1] | phase_power_b[ES_PW-1] | phase_power_c[ES_PW-1];
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_answer;
    ##2 s_axi_bvalid;
  endsequence
  a_ab_apart: assert property (!($rose(pulse_out_a) && $rose(pulse_out_b)))
    else $error("a and b rose together");
  a_cf_width: assert property ($rose(calibration_pulse_out) |=> calibration_pulse_out[*8])
    else $error("calibration pulse too short");
  a_pulse_load: assert property (($rose(pulse_out_a) || $rose(calibration_pulse_out))
    |-> $past(load, 2)) else $error("pulse without load");
  a_rev_cause: assert property ($rose(reverse_power_flag) |-> $past(neg, 2))
    else $error("reverse flag without negative phase");
  a_rev_with_cf: assert property ($changed(reverse_power_flag) |-> calibration_pulse_out)
    else $error("reverse flag moved outside a calibration pulse");
  a_write_answer: assert property (aw_w_taken |-> b_answer)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read data late");
endmodule
bind es_pulse_rate_scaler es_pulse_rate_scaler_asserts i_chk (.*);
`default_nettype wire

// file: verif/es_pulse_rate_scaler_tb_top.sv
/*
  Testbench: AXI4-Lite register tasks and timed pulse scenarios.
  Assumes the design, the counter model and the checker compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module es_pulse_rate_scaler_tb_top import es_pkg::*; ;
  localparam int CLK = 1_000_000;
  localparam int FS  = ES_PHASE_FS;
  logic                    aclk = 1'b0;
  logic                    aresetn, magnitude_sum_select_n, cal_scale_select;
  logic                    rate_select_hi, rate_select_lo, pulse_out_a, pulse_out_b;
  logic                    calibration_pulse_out, reverse_power_flag, irq;
  logic signed [ES_PW-1:0] phase_power_a, phase_power_b, phase_power_c;
  logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                    s_axi_rvalid, s_axi_rready;
  logic [ES_ADDR_W-1:0]    s_axi_awaddr, s_axi_araddr;
  logic [31:0]             s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0]              s_axi_wstrb = 4'hf;
  logic [1:0]              s_axi_bresp, s_axi_rresp, resp_q;
  int                      n_fail, checks_done, cyc, n_a, n_b, n_cf, t_a, t_b, t_cf;

  es_pulse_rate_scaler #(.CLK_HZ(CLK)) i_dut (.*);
  es_pulse_counter i_cnt (.*);
  always #10 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      resp_q = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      {rd_q, resp_q} = {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!r);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic go(input logic [2:0] sel, input logic md, input int a, b, c);
    aresetn <= 1'b0;
    {cal_scale_select, rate_select_hi, rate_select_lo} <= sel;
    magnitude_sum_select_n <= md;
    {phase_power_a, phase_power_b, phase_power_c} <= {ES_PW'(a), ES_PW'(b), ES_PW'(c)};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  // Cycles per accumulation tick, and cycles until the crossing tick
  function automatic longint tk(int sel);
    return CLK * ES_CHZ_PER_HZ / (ES_BASE_CHZ[sel] * ES_ACC_MULT);
  endfunction
  function automatic longint due(longint thr, int s, int sel);
    return (thr + s - 1) / s * tk(sel);
  endfunction
  // The divider phase at release is unknown, so allow one tick early
  function automatic logic inwin(int t, longint thr, int s, int sel);
    return t >= due(thr, s, sel) - tk(sel) && t <= due(thr, s, sel) + 8;
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    {n_fail, checks_done} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    go(3'h3, 1'b0, FS, FS, -FS);
    rd(ES_REG_CTRL);
    chk(rd_q, 32'h1);
    rd(8'h40);
    chk(resp_q, ES_RESP_SLVERR);
    wr(ES_REG_MASK, 32'h4);
    chk(resp_q, ES_RESP_OKAY);
    while (n_cf == 0) @(posedge aclk);
    @(negedge aclk);
    chk(reverse_power_flag, 1'b1);
    chk(irq, 1'b1);
    chk(inwin(t_cf, ES_THRESH / ES_CF_MULT[3], 3 * FS, 3), 1'b1);
    // Bus requests start on a rising edge, never from the falling-edge check
    @(posedge aclk);
    wr(ES_REG_STATUS, 32'h4);
    @(negedge aclk);
    chk(irq, 1'b0);
    while (n_b == 0) @(posedge aclk);
    chk(inwin(t_a, ES_THRESH / 2, 3 * FS, 3), 1'b1);
    chk(inwin(t_b, 2 * (ES_THRESH / 2), 3 * FS, 3), 1'b1);
    $display("test magnitude sum done");
    go(3'h3, 1'b1, FS, FS, -FS);
    while (n_cf == 0) @(posedge aclk);
    chk(inwin(t_cf, ES_THRESH / ES_CF_MULT[3], FS, 3), 1'b1);
    $display("test signed sum done");
    for (int s = 0; s < ES_NSEL; s++) begin
      go(3'(s), 1'b1, FS, FS, FS);
      rd(ES_REG_STATE);
      chk(rd_q[5:2], {1'b1, 3'(s)});
      if (due(ES_THRESH / ES_CF_MULT[s], 3 * FS, s) < 12000) begin
        while (n_cf == 0) @(posedge aclk);
        chk(inwin(t_cf, ES_THRESH / ES_CF_MULT[s], 3 * FS, s), 1'b1);
      end
    end
    $display("test select patterns done");
    // Total just under the creep level
    go(3'h3, 1'b1, 205, 205, 205);
    repeat (3000) @(posedge aclk);
    rd(ES_REG_STATE);
    chk(rd_q[1], 1'b1);
    chk(n_cf + n_a, 0);
    $display("test no load done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
